//--- rvp_port.sv
// What this block does
// - The two-bit format field picks 18-bit, 16-bit or 6-bit pixel buses, and code 11 writes nothing.
// - Frame and line timing come from the incoming syncs and pixel clock, not a local oscillator.
// - With a window set and fast write mode on, pixels land only inside the window.
// - Four polarity bits invert the sense of pixel clock, enable, line sync and frame sync.
// - In 6-bit mode three transfers make one 18-bit pixel, and the source sends whole pixels.
// - Received pixels go straight into the display memory, which the display path reads.
// - A word is stored on a pixel clock only while enable is active, and ignored otherwise.
// - The 6-bit transfer counter restarts on each frame sync edge into its active level (falling edge when active low).
// - Each frame sync edge into its active level (falling edge when active low) reloads the write address with the start address.
// - After the last line the port waits in front porch until the next frame sync.
module rvp_port
  import rvp_pkg::*;
(
  input wire logic clk, // register and display clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [3:0] reg_addr, // register word address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic pixel_clock, // link pixel clock
  input wire logic frame_sync_n, // frame sync pin
  input wire logic line_sync_n, // line sync pin
  input wire logic data_enable_n, // data enable pin
  input wire logic [17:0] pixel_data_bus, // pixel data pins
  input wire logic [16:0] disp_rd_addr, // display readout address
  output logic [17:0] disp_rd_data // display readout word
);
  typedef enum logic {rvp_front, rvp_active} rvp_state_e;

  // ---------------- register side (clk) ----------------
  logic [7:0] ctrl;
  logic [16:0] start_addr;
  logic [7:0] h_start, h_end;
  logic [8:0] v_start, v_end;
  logic [15:0] frame_cnt;
  logic [9:0] lines_seen;
  logic frame_tgl_s, frame_tgl_d, state_s;
  logic [9:0] frame_lines;
  logic frame_tgl, link_rst;
  rvp_state_e state;

  // software writes; unmapped writes are ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
      start_addr <= START_RESET;
      h_start <= HWIN_START_RESET;
      h_end <= HWIN_END_RESET;
      v_start <= VWIN_START_RESET;
      v_end <= VWIN_END_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl <= reg_wdata[7:0];
      end else if (reg_addr == OFS_START) begin
        start_addr <= reg_wdata[16:0];
      end else if (reg_addr == OFS_HWIN) begin
        h_start <= reg_wdata[7:0];
        h_end <= reg_wdata[WIN_END_LSB +: 8];
      end else if (reg_addr == OFS_VWIN) begin
        v_start <= reg_wdata[8:0];
        v_end <= reg_wdata[WIN_END_LSB +: 9];
      end
    end
  end

  // reads answer one cycle later; unmapped and idle cycles give zero
  always_ff @(posedge clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == OFS_CTRL) begin
      reg_rdata <= {24'h000000, ctrl};
    end else if (reg_addr == OFS_START) begin
      reg_rdata <= {15'h0000, start_addr};
    end else if (reg_addr == OFS_HWIN) begin
      reg_rdata <= {8'h00, h_end, 8'h00, h_start};
    end else if (reg_addr == OFS_VWIN) begin
      reg_rdata <= {7'h00, v_end, 7'h00, v_start};
    end else if (reg_addr == OFS_STATUS) begin
      reg_rdata <= {frame_cnt, 4'h0, (ctrl[CTRL_FMT_LSB +: 2] == FMT_BAD), state_s,
        lines_seen};
    end else begin
      reg_rdata <= '0;
    end
  end

  // frame events cross as a toggle; the line count is held stable a whole frame
  rvp_sync #(.WIDTH(2)) u_back_sync (
    .clk(clk),
    .d({frame_tgl, state == rvp_active}),
    .q({frame_tgl_s, state_s})
  );

  // frame counter and lines-per-frame, both timed by the link syncs
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_tgl_d <= 1'b0;
      frame_cnt <= '0;
      lines_seen <= '0;
    end else begin
      frame_tgl_d <= frame_tgl_s;
      if (frame_tgl_s != frame_tgl_d) begin
        frame_cnt <= frame_cnt + 16'h0001;
        lines_seen <= frame_lines;
      end
    end
  end

  // ---------------- link side (pixel clock) ----------------
  logic link_clk;
  logic [57:0] cfg_s;
  logic [1:0] fmt;
  logic fast, path, de_pol, hs_pol, vs_pol;
  logic [16:0] l_start;
  logic [7:0] l_hs, l_he;
  logic [8:0] l_vs, l_ve;

  // clock polarity flips the capture edge; change it only while the link is idle
  assign link_clk = pixel_clock ^ ctrl[CTRL_PCLK_POL_BIT];

  // configuration is quasi-static and crosses bit by bit
  rvp_sync #(.WIDTH(58)) u_cfg_sync (
    .clk(link_clk),
    .d({ctrl[CTRL_FMT_LSB +: 2], ctrl[CTRL_FAST_BIT], ctrl[CTRL_PATH_BIT],
      ctrl[CTRL_DE_POL_BIT], ctrl[CTRL_HS_POL_BIT], ctrl[CTRL_VS_POL_BIT],
      start_addr, h_start, h_end, v_start, v_end}),
    .q(cfg_s)
  );
  assign {fmt, fast, path, de_pol, hs_pol, vs_pol, l_start, l_hs, l_he, l_vs, l_ve} = cfg_s;

  rvp_sync #(.WIDTH(1)) u_rst_sync (
    .clk(link_clk),
    .d(srst),
    .q(link_rst)
  );

  logic vs_q, hs_q, de_q, vs_act_d, hs_act_d;
  logic [17:0] db_q;
  logic vs_act, hs_act, de_act, vs_start, hs_start;

  // pins are sampled on the pixel clock, which is their own domain
  always_ff @(posedge link_clk) begin
    vs_q <= frame_sync_n;
    hs_q <= line_sync_n;
    de_q <= data_enable_n;
    db_q <= pixel_data_bus;
  end

  // polarity bit clear means active low
  assign vs_act = ~(vs_q ^ vs_pol);
  assign hs_act = ~(hs_q ^ hs_pol);
  assign de_act = ~(de_q ^ de_pol);
  assign vs_start = vs_act & ~vs_act_d;
  assign hs_start = hs_act & ~hs_act_d;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      vs_act_d <= 1'b0;
      hs_act_d <= 1'b0;
    end else begin
      vs_act_d <= vs_act;
      hs_act_d <= hs_act;
    end
  end

  // 6-bit transfer counter and colour accumulator
  logic [1:0] sub_cnt;
  logic [11:0] acc;
  always_ff @(posedge link_clk) begin
    if (link_rst || vs_start) begin
      sub_cnt <= 2'h0;
      acc <= '0;
    end else if (de_act && fmt == FMT_6) begin
      sub_cnt <= (sub_cnt == 2'h2) ? 2'h0 : sub_cnt + 2'h1;
      acc <= {acc[5:0], db_q[17:12]};
    end
  end

  // pixel assembly per bus format
  logic [17:0] pixel;
  logic pix_valid;
  always_comb begin
    pixel = db_q;
    pix_valid = 1'b0;
    case (fmt)
      FMT_18: begin
        pixel = db_q;
        pix_valid = de_act;
      end
      FMT_16: begin
        // red and blue get their top bit repeated into the spare lsb
        pixel = {db_q[17:13], db_q[17], db_q[11:6], db_q[5:1], db_q[5]};
        pix_valid = de_act;
      end
      FMT_6: begin
        pixel = {acc, db_q[17:12]};
        pix_valid = de_act && sub_cnt == 2'h2;
      end
      default: begin
        pix_valid = 1'b0;
      end
    endcase
  end

  // frame walker: window origin at frame sync, front porch after last line
  logic [16:0] wr_addr;
  logic [7:0] col;
  logic [8:0] row;
  logic ram_we;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= rvp_front;
      wr_addr <= START_RESET;
      col <= HWIN_START_RESET;
      row <= VWIN_START_RESET;
    end else if (vs_start) begin
      state <= rvp_active;
      wr_addr <= l_start;
      col <= l_hs;
      row <= l_vs;
    end else if (pix_valid && state == rvp_active) begin
      if (col == l_he) begin
        col <= l_hs;
        wr_addr <= wr_addr + 17'(LINE_PIXELS) - 17'(l_he - l_hs);
        if (row == l_ve) begin
          state <= rvp_front;
        end else begin
          row <= row + 9'h001;
        end
      end else begin
        col <= col + 8'h01;
        wr_addr <= wr_addr + 17'h00001;
      end
    end
  end

  // writes need fast write mode and the port owning the memory path
  assign ram_we = pix_valid && state == rvp_active && fast && path;

  // line counting from the line sync, handed over once per frame
  logic [9:0] line_cnt;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      line_cnt <= '0;
      frame_lines <= '0;
      frame_tgl <= 1'b0;
    end else if (vs_start) begin
      line_cnt <= '0;
      frame_lines <= line_cnt;
      frame_tgl <= ~frame_tgl;
    end else if (hs_start) begin
      line_cnt <= line_cnt + 10'h001;
    end
  end

  rvp_ram u_ram (
    .wclk(link_clk),
    .we(ram_we),
    .waddr(wr_addr),
    .wdata(pixel),
    .rclk(clk),
    .raddr(disp_rd_addr),
    .rdata(disp_rd_data)
  );

  // ---------------- checks ----------------
  sequence frame_edge_s;
    vs_start;
  endsequence

  sequence reloaded_s;
    wr_addr == $past(l_start) && sub_cnt == 2'h0;
  endsequence

  sub_range_a: assert property (@(posedge link_clk) disable iff (link_rst)
    sub_cnt != 2'h3) else $error("six-bit counter left range");
  addr_reload_a: assert property (@(posedge link_clk) disable iff (link_rst)
    frame_edge_s |=> reloaded_s) else $error("start address not reloaded");
  sub_clear_a: assert property (@(posedge link_clk) disable iff (link_rst)
    frame_edge_s |=> sub_cnt == 2'h0 && state == rvp_active) else $error("counter not cleared");
  enable_gate_a: assert property (@(posedge link_clk) disable iff (link_rst)
    !de_act |-> !ram_we) else $error("write while enable inactive");
  front_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == rvp_front && !vs_start |=> state == rvp_front) else $error("left front porch");
  window_only_a: assert property (@(posedge link_clk) disable iff (link_rst)
    ram_we |-> row <= l_ve && col >= l_hs && col <= l_he && fast) else $error("write off window");
  bad_format_a: assert property (@(posedge link_clk) disable iff (link_rst)
    fmt == FMT_BAD |-> !ram_we) else $error("write in forbidden format");
  six_group_a: assert property (@(posedge link_clk) disable iff (link_rst)
    ram_we && fmt == FMT_6 && !$past(vs_start) |-> sub_cnt == 2'h2 && $past(sub_cnt) != 2'h2)
    else $error("six-bit pixel not from three transfers");
  line_hand_a: assert property (@(posedge link_clk) disable iff (link_rst)
    frame_edge_s |=> frame_lines == $past(line_cnt) && line_cnt == 10'h000)
    else $error("line count not handed over");
endmodule

//--- rvp_pkg.sv
package rvp_pkg;
  // register word addresses on the plain register port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_START = 4'h1;
  localparam logic [3:0] OFS_HWIN = 4'h2;
  localparam logic [3:0] OFS_VWIN = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // control register fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_PATH_BIT = 3;
  localparam int CTRL_PCLK_POL_BIT = 4;
  localparam int CTRL_DE_POL_BIT = 5;
  localparam int CTRL_HS_POL_BIT = 6;
  localparam int CTRL_VS_POL_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // window register fields: start in low half, end in high half
  localparam int WIN_END_LSB = 16;
  localparam logic [7:0] HWIN_START_RESET = 8'h00;
  localparam logic [7:0] HWIN_END_RESET = 8'hef;
  localparam logic [8:0] VWIN_START_RESET = 9'h000;
  localparam logic [8:0] VWIN_END_RESET = 9'h1af;
  localparam logic [16:0] START_RESET = 17'h00000;

  // status register fields
  localparam int STAT_STATE_BIT = 10;
  localparam int STAT_FMT_ERR_BIT = 11;
  localparam int STAT_FRAMES_LSB = 16;

  // bus format codes of the format select field
  localparam logic [1:0] FMT_18 = 2'h0;
  localparam logic [1:0] FMT_16 = 2'h1;
  localparam logic [1:0] FMT_6 = 2'h2;
  localparam logic [1:0] FMT_BAD = 2'h3;

  // geometry of the display memory, and synchroniser depth
  localparam int LINE_PIXELS = 240;
  localparam int RAM_WORDS = 103680;
  localparam int ADDR_W = 17;
  localparam int PIX_W = 18;
  localparam int SYNC_STAGES = 2;
endpackage

//--- rvp_sync.sv
// two-stage level synchroniser, one pair of flops per bit
module rvp_sync
  import rvp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic [WIDTH-1:0] d, // level from another domain
  output logic [WIDTH-1:0] q // synchronised level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage;
      // first stage feeds only the second
      always_ff @(posedge clk) begin
        stage <= {stage[SYNC_STAGES-2:0], d[i]};
      end
      assign q[i] = stage[SYNC_STAGES-1];
    end
  endgenerate
endmodule

//--- rvp_ram.sv
// display memory: written from the link clock, read by the display path
module rvp_ram
  import rvp_pkg::*;
#(
  parameter int DEPTH = RAM_WORDS,
  parameter int AW = ADDR_W,
  parameter int DW = PIX_W
) (
  input wire logic wclk, // link-side write clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [DW-1:0] wdata, // pixel to store
  input wire logic rclk, // display-side clock
  input wire logic [AW-1:0] raddr, // read address
  output logic [DW-1:0] rdata // read word, one cycle later
);
  logic [DW-1:0] mem [DEPTH];

  // write port; addresses past the end are dropped
  always_ff @(posedge wclk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // read port; a read racing a write of the same word may see either value
  always_ff @(posedge rclk) begin
    if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end
endmodule

//--- rvp_src.sv
// video source model: drives syncs, pixel clock, enable and data of the link
module rvp_src
  import rvp_pkg::*;
(
  input wire logic [3:0] pol, // polarity {frame, line, enable, clock}
  output logic pixel_clock, // link pixel clock
  output logic frame_sync_n, // frame sync pin
  output logic line_sync_n, // line sync pin
  output logic data_enable_n, // data enable pin
  output logic [17:0] pixel_data_bus // pixel data pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_raw, vs, hs, de;
  logic [17:0] words[$];
  // levels are active high inside and turned to pin sense here
  assign pixel_clock = clk_raw ^ pol[0];
  assign data_enable_n = ~de ^ pol[1];
  assign line_sync_n = ~hs ^ pol[2];
  assign frame_sync_n = ~vs ^ pol[3];
  // clock stands still until idle or frame asks for link cycles
  initial begin
    clk_raw = 1'b0;
    {vs, hs, de} = 3'b000;
    pixel_data_bus = 18'h00000;
  end
  // one link cycle: pins change half a period before the capture edge
  task automatic tick(input logic v, input logic h, input logic e, input logic [17:0] d);
    {vs, hs, de} = {v, h, e};
    pixel_data_bus = d;
    #80 clk_raw = 1'b1;
    #80 clk_raw = 1'b0;
  endtask
  // released bus shows the inverse of its last value, never a stale copy
  task automatic idle(input int n);
    repeat (n) tick(1'b0, 1'b0, 1'b0, ~pixel_data_bus);
  endtask
  // whole frame; 6-bit callers send whole pixels unless a fault is wanted
  task automatic frame(input int lines, input int per_line, input int gap);
    idle(4); // lets synchronised settings settle
    repeat (2) tick(1'b1, 1'b0, 1'b0, ~pixel_data_bus);
    idle(2); // back porch
    repeat (lines) begin
      tick(1'b0, 1'b1, 1'b0, ~pixel_data_bus);
      repeat (per_line) begin
        tick(1'b0, 1'b0, 1'b1, words.pop_front());
        repeat (gap) tick(1'b0, 1'b0, 1'b0, ~pixel_data_bus); // slow source
      end
    end
    idle(3); // front porch
  endtask
endmodule

//--- rvp_port_tb_top.sv
// self-checking bench for the pixel input port
module rvp_port_tb_top
  import rvp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, reg_wr, reg_rd, mem_rd, rd_q, mem_q;
  logic [3:0] reg_addr, pol;
  logic [31:0] reg_wdata, reg_rdata, seed, ev, em;
  logic [16:0] disp_rd_addr, base;
  logic [17:0] disp_rd_data, ep;
  logic pixel_clock, frame_sync_n, line_sync_n, data_enable_n;
  logic [17:0] pixel_data_bus;
  logic [31:0] exp_v[$], exp_m[$];
  logic [17:0] exp_p[$];
  logic [17:0] mdl[int];
  int err_count, checked;

  // only this port carries pixels
  rvp_port i_rvp_port (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pixel_clock(pixel_clock),
    .frame_sync_n(frame_sync_n), .line_sync_n(line_sync_n), .data_enable_n(data_enable_n),
    .pixel_data_bus(pixel_data_bus), .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data));
  rvp_src i_rvp_src (.pol(pol), .pixel_clock(pixel_clock), .frame_sync_n(frame_sync_n),
    .line_sync_n(line_sync_n), .data_enable_n(data_enable_n), .pixel_data_bus(pixel_data_bus));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up;
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    exp_v.push_back(e);
    exp_m.push_back(m);
    @(posedge clk) reg_rd <= 1'b0;
  endtask
  task automatic mem(input logic [16:0] a, input logic [17:0] e);
    @(posedge clk) {disp_rd_addr, mem_rd} <= {a, 1'b1};
    exp_p.push_back(e);
    @(posedge clk) mem_rd <= 1'b0;
  endtask
  // configure, send one frame, note what memory must hold, then read it all
  task automatic run(input logic [1:0] fmt, input logic [3:0] p, input int cols,
                     input int rows, input int n, input int gap);
    logic [17:0] w, px;
    int k, sub;
    k = 0;
    sub = 0;
    px = 18'h00000;
    wr(OFS_CTRL, {24'h000000, p, 2'b11, fmt});
    wr(OFS_START, {15'h0000, base});
    wr(OFS_HWIN, {8'h00, 8'(cols + 2), 8'h00, 8'h03});
    wr(OFS_VWIN, {7'h00, 9'(rows + 4), 7'h00, 9'h005});
    pol = p;
    for (int i = 0; i < n; i++) begin
      w = 18'($random(seed));
      if (fmt == FMT_6) w[11:0] = 12'h000; // unused pins held low
      if (fmt == FMT_16) {w[12], w[0]} = 2'b00;
      i_rvp_src.words.push_back(w);
      px = (fmt == FMT_18) ? w : (fmt == FMT_16) ? {w[17:13], w[17], w[11:6], w[5:1], w[5]} :
           {px[11:0], w[17:12]};
      if (fmt != FMT_6 || sub == 2) begin
        if (k < cols * rows && fmt != FMT_BAD)
          mdl[int'(base) + (k / cols) * LINE_PIXELS + k % cols] = px;
        k++;
      end
      sub = (fmt == FMT_6) ? (sub + 1) % 3 : 0;
    end
    i_rvp_src.frame(2, n / 2, gap);
    foreach (mdl[a]) mem(17'(a), mdl[a]);
  endtask

  // stimulus: reset with the link ticking, then frames in every format
  initial begin
    {srst, reg_wr, reg_rd, mem_rd} = 4'b1000;
    {reg_addr, reg_wdata, disp_rd_addr, pol} = '0;
    seed = 32'h7868;
    fork
      i_rvp_src.idle(6);
    join_none
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, {24'h000000, CTRL_RESET}, '1);
    rd(OFS_START, {15'h0000, START_RESET}, '1);
    rd(OFS_HWIN, {8'h00, HWIN_END_RESET, 8'h00, HWIN_START_RESET}, '1);
    rd(OFS_VWIN, {7'h00, VWIN_END_RESET, 7'h00, VWIN_START_RESET}, '1);
    rd(4'h9, 32'h00000000, '1); // unmapped reads zero
    base = 17'($random(seed)) & 17'h0ffff;
    run(FMT_18, 4'h0, 3, 2, 6, 0);
    run(FMT_18, 4'h0, 2, 1, 6, 0);
    run(FMT_16, 4'hf, 3, 2, 6, 1);
    run(FMT_6, 4'h0, 3, 2, 8, 0);
    run(FMT_6, 4'h0, 3, 2, 6, 0);
    run(FMT_BAD, 4'h0, 3, 2, 6, 0);
    // six frames seen, two lines in the last full one, link left active, format bad
    rd(OFS_STATUS, 32'h00060c02, 32'hffffffff);
    rd(OFS_CTRL, {24'h000000, 4'h0, 2'b11, FMT_BAD}, '1);
    rd(OFS_START, {15'h0000, base}, '1);
    repeat (2) @(posedge clk);
    wrap_up();
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk);
    $display("ERROR run_time expected finish seen hang");
    err_count++;
    wrap_up();
  end

  // monitor: oldest note is compared when a result stands
  always @(posedge clk) begin
    rd_q <= reg_rd;
    mem_q <= mem_rd;
    if (rd_q === 1'b1) begin
      ev = exp_v.pop_front();
      em = exp_m.pop_front();
      checked++;
      if ((reg_rdata & em) !== (ev & em)) begin
        $display("ERROR reg_rdata expected %h seen %h", ev, reg_rdata);
        err_count++;
      end
    end
    if (mem_q === 1'b1) begin
      ep = exp_p.pop_front();
      checked++;
      if (disp_rd_data !== ep) begin
        $display("ERROR disp_rd_data expected %h seen %h", ep, disp_rd_data);
        err_count++;
      end
    end
  end
endmodule
